// [pkg/ctl_regs_pkg.sv]
// constants for the host control register bank of the audio processor
package ctl_regs_pkg;
   localparam int          ADDR_W           = 12;
   localparam int          DATA_W           = 32;
   localparam int          PARAM_W          = 28;
   localparam int          AUX_W            = 12;
   localparam int          AUX_RAW_W        = 8;
   localparam int          NUM_SAVED        = 8;
   localparam int          NUM_PINS         = 12;
   localparam int          NUM_AUX          = 4;
   // register addresses, as printed (word index on the control port)
   localparam logic [11:0] A_SAVED_FIRST    = 12'h800;
   localparam logic [11:0] A_SAVED_LAST     = 12'h807;
   localparam logic [11:0] A_PIN_LEVEL      = 12'h808;
   localparam logic [11:0] A_AUX_FIRST      = 12'h809;
   localparam logic [11:0] A_AUX_LAST       = 12'h80c;
   localparam logic [11:0] A_CORE_CTRL      = 12'h81c;
   localparam logic [11:0] A_RSVD_A         = 12'h81d;
   localparam logic [11:0] A_SER_OUT        = 12'h81e;
   localparam logic [11:0] A_SER_IN         = 12'h81f;
   localparam logic [11:0] A_PIN_CFG_LO     = 12'h820;
   localparam logic [11:0] A_PIN_CFG_HI     = 12'h821;
   localparam logic [11:0] A_AUX_PWR        = 12'h822;
   localparam logic [11:0] A_RSVD_B         = 12'h823;
   localparam logic [11:0] A_AUX_EN         = 12'h824;
   localparam logic [11:0] A_RSVD_C         = 12'h825;
   localparam logic [11:0] A_OSC_OFF        = 12'h826;
   localparam logic [11:0] A_DAC_CFG        = 12'h827;
   // core control fields
   localparam int          B_AUX_PORT_WR    = 8;
   localparam int          B_PIN_PORT_WR    = 7;
   localparam int          B_SAVED_PORT_WR  = 6;
   localparam int          B_SAFELOAD_INIT  = 5;
   localparam logic [15:0] M_CORE_CTRL      = 16'h31ff;
   // writable masks of the remaining registers
   localparam logic [15:0] M_SER_OUT        = 16'h3fff;
   localparam logic [7:0]  M_SER_IN         = 8'h1f;
   localparam logic [15:0] M_AUX_PWR        = 16'h03ef;
   localparam int          B_FILTER_LO      = 8;
   localparam int          B_AUX_CONV_OFF   = 7;
   localparam int          B_AUX_CONV_ON    = 15;
   localparam int          B_OSC_OFF        = 2;
   localparam logic [15:0] M_DAC_CFG        = 16'h0003;
   localparam int          PIN_CFG_W        = 24;
   // reset values
   localparam logic [15:0] RST_CTRL16       = 16'h0000;
   localparam logic [7:0]  RST_CTRL8        = 8'h00;
   // auxiliary result scaling: full-scale raw code maps to 1.0 in 1.11
   localparam logic [7:0]  AUX_FULL_CODE    = 8'hff;
   localparam logic [11:0] AUX_ONE          = 12'h800;
   localparam int          AUX_PAD_LO       = 12;
   localparam int          PARAM_PAD_HI     = 4;
endpackage

// [core/dsp_host_control_registers.sv]
// host control register bank: saved parameters, pin levels, aux results, setup
//
// Overview of operation
// - eight saved parameters, 28 bits, top four zero
// - saved words refresh from parameter ram each frame
// - chosen trigger edge starts saving words to eeprom
// - eeprom contents reload saved words after reset
// - saved-word port-write mode takes host writes instead
// - pin levels writable only in pin port-write mode
// - pin level outputs update once per frame
// - one result register per auxiliary converter channel
// - eight bits unfiltered, twelve bits when filtered
// - result seen as 1.11 inside zero-padded 5.23
// - raw full-scale code 255 gives exactly 1.0
// - aux port-write mode accepts host result writes
// - result in bits 11:0, upper bits read zero
// - core control holds mode bits 13:12 and 8:0
// - aux/power control: filter 9:8, power-downs 7:5,3:0
// - aux enable register holds only bit 15
// - oscillator power-down register holds only bit 2
// - serial output control, top two bits zero
// - serial input control, eight bits, top three zero
// - two 24-bit pin config registers, nibble per pin
`timescale 1ns/1ps
`default_nettype none
module dsp_host_control_registers
   import ctl_regs_pkg::*;
#(
   parameter int NUM_SAVED_P = ctl_regs_pkg::NUM_SAVED,
   parameter int NUM_PINS_P  = ctl_regs_pkg::NUM_PINS,
   parameter int NUM_AUX_P   = ctl_regs_pkg::NUM_AUX
) (
   input  wire logic                                          clk,
   input  wire logic                                          clk_en,
   input  wire logic                                          reset,
   input  wire logic [ctl_regs_pkg::ADDR_W-1:0]               reg_addr,
   input  wire logic                                          reg_wr,
   input  wire logic [ctl_regs_pkg::DATA_W-1:0]               reg_wdata,
   input  wire logic                                          reg_rd,
   output logic      [ctl_regs_pkg::DATA_W-1:0]               reg_rdata,
   input  wire logic                                          frame_clk,
   input  wire logic [NUM_SAVED_P-1:0][ctl_regs_pkg::PARAM_W-1:0] param_ram_word,
   input  wire logic                                          save_trigger,
   input  wire logic                                          save_on_rising,
   output logic                                               save_start,
   output logic      [NUM_SAVED_P-1:0][ctl_regs_pkg::PARAM_W-1:0] save_words,
   input  wire logic                                          restore_valid,
   input  wire logic [2:0]                                    restore_index,
   input  wire logic [ctl_regs_pkg::PARAM_W-1:0]              restore_word,
   input  wire logic [NUM_PINS_P-1:0]                         multipurpose_pin_in,
   output logic      [NUM_PINS_P-1:0]                         multipurpose_pin_levels,
   input  wire logic [NUM_AUX_P-1:0][ctl_regs_pkg::AUX_RAW_W-1:0] aux_raw_code,
   input  wire logic [NUM_AUX_P-1:0][ctl_regs_pkg::AUX_W-1:0] aux_filtered_code,
   output logic      [NUM_AUX_P-1:0][ctl_regs_pkg::PARAM_W-1:0] aux_param_word,
   output logic      [15:0]                                   core_control,
   output logic      [15:0]                                   serial_out_control,
   output logic      [7:0]                                    serial_in_control,
   output logic      [2*ctl_regs_pkg::PIN_CFG_W-1:0]          pin_config,
   output logic      [1:0]                                    aux_filter_select,
   output logic      [15:0]                                   aux_and_power_control,
   output logic                                               aux_converter_on,
   output logic                                               oscillator_off,
   output logic      [15:0]                                   dac_config
);
   import ctl_regs_pkg::*;

   if (NUM_SAVED_P != NUM_SAVED || NUM_PINS_P != NUM_PINS || NUM_AUX_P != NUM_AUX) begin : g_chk
      $error("register map is fixed at eight saved words, twelve pins, four channels");
   end

   typedef struct packed {
      logic                                     fr_s1;
      logic                                     fr_s2;
      logic                                     fr_prev;
      logic                                     tr_s1;
      logic                                     tr_s2;
      logic                                     tr_prev;
      logic [NUM_PINS-1:0]                      mp_s1;
      logic [NUM_PINS-1:0]                      mp_s2;
      logic [NUM_SAVED-1:0][PARAM_W-1:0]        saved;
      logic [NUM_SAVED-1:0][PARAM_W-1:0]        snap;
      logic                                     save_start;
      logic [NUM_PINS-1:0]                      pin_lvl;
      logic [NUM_PINS-1:0]                      pin_out;
      logic [NUM_AUX-1:0][AUX_W-1:0]            aux;
      logic [15:0]                              core;
      logic [15:0]                              ser_out;
      logic [7:0]                               ser_in;
      logic [1:0][PIN_CFG_W-1:0]                pin_cfg;
      logic [15:0]                              aux_pwr;
      logic                                     aux_on;
      logic                                     osc_off;
      logic [15:0]                              dac;
      logic [DATA_W-1:0]                        rdata;
   } regs_s;

   regs_s st_ff;
   regs_s nxt_st;
   logic  frame_tick;
   logic  save_edge;
   logic  hwr;

   // unfiltered code is scaled by 8 so 255 must be pinned to 1.0 explicitly
   function automatic logic [AUX_W-1:0] aux_scale(input logic [1:0]           filt,
                                                 input logic [AUX_RAW_W-1:0] raw,
                                                 input logic [AUX_W-1:0]     fil);
      logic [AUX_W-1:0] v;
      v = '0;
      if (filt != 2'b00) begin
         v = (fil > AUX_ONE) ? AUX_ONE : fil;
      end else if (raw == AUX_FULL_CODE) begin
         v = AUX_ONE;
      end else begin
         v = {1'b0, raw, 3'b000};
      end
      return v;
   endfunction

   // synchronised frame clock: first stage is read only by the second
   assign frame_tick = st_ff.fr_s2 & ~st_ff.fr_prev;
   assign save_edge  = save_on_rising ? (st_ff.tr_s2 & ~st_ff.tr_prev)
                                      : (~st_ff.tr_s2 & st_ff.tr_prev);
   assign hwr        = clk_en & reg_wr;

   always_comb begin
      nxt_st            = st_ff;
      nxt_st.fr_s1      = frame_clk;
      nxt_st.fr_s2      = st_ff.fr_s1;
      nxt_st.fr_prev    = st_ff.fr_s2;
      nxt_st.tr_s1      = save_trigger;
      nxt_st.tr_s2      = st_ff.tr_s1;
      nxt_st.tr_prev    = st_ff.tr_s2;
      nxt_st.mp_s1      = multipurpose_pin_in;
      nxt_st.mp_s2      = st_ff.mp_s1;
      nxt_st.save_start = 1'b0;
      if (save_edge) begin
         nxt_st.save_start = 1'b1;
         nxt_st.snap       = st_ff.saved;
      end
      if (frame_tick) begin
         if (!st_ff.core[B_SAVED_PORT_WR]) begin
            nxt_st.saved = param_ram_word;
         end
         if (!st_ff.core[B_PIN_PORT_WR]) begin
            nxt_st.pin_lvl = st_ff.mp_s2;
         end
         nxt_st.pin_out = st_ff.pin_lvl;
         if (!st_ff.core[B_AUX_PORT_WR]) begin
            for (int i = 0; i < NUM_AUX; i++) begin
               nxt_st.aux[i] = aux_scale(st_ff.aux_pwr[B_FILTER_LO +: 2],
                                         aux_raw_code[i], aux_filtered_code[i]);
            end
         end
      end
      if (reg_wr) begin
         if (reg_addr >= A_SAVED_FIRST && reg_addr <= A_SAVED_LAST) begin
            if (st_ff.core[B_SAVED_PORT_WR]) begin
               nxt_st.saved[reg_addr[2:0]] = reg_wdata[PARAM_W-1:0];
            end
         end else if (reg_addr == A_PIN_LEVEL) begin
            if (st_ff.core[B_PIN_PORT_WR]) begin
               nxt_st.pin_lvl = reg_wdata[NUM_PINS-1:0];
            end
         end else if (reg_addr >= A_AUX_FIRST && reg_addr <= A_AUX_LAST) begin
            if (st_ff.core[B_AUX_PORT_WR]) begin
               nxt_st.aux[2'(reg_addr - A_AUX_FIRST)] = reg_wdata[AUX_W-1:0];
            end
         end else begin
            case (reg_addr)
               A_CORE_CTRL:  nxt_st.core    = reg_wdata[15:0] & M_CORE_CTRL;
               A_SER_OUT:    nxt_st.ser_out = reg_wdata[15:0] & M_SER_OUT;
               A_SER_IN:     nxt_st.ser_in  = reg_wdata[7:0] & M_SER_IN;
               A_PIN_CFG_LO: nxt_st.pin_cfg[0] = reg_wdata[PIN_CFG_W-1:0];
               A_PIN_CFG_HI: nxt_st.pin_cfg[1] = reg_wdata[PIN_CFG_W-1:0];
               A_AUX_PWR:    nxt_st.aux_pwr = reg_wdata[15:0] & M_AUX_PWR;
               A_AUX_EN:     nxt_st.aux_on  = reg_wdata[B_AUX_CONV_ON];
               A_OSC_OFF:    nxt_st.osc_off = reg_wdata[B_OSC_OFF];
               A_DAC_CFG:    nxt_st.dac     = reg_wdata[15:0] & M_DAC_CFG;
               default: begin
               end
            endcase
         end
      end
      // boot loader restores last, so a restored word beats a same-cycle refresh
      if (restore_valid) begin
         nxt_st.saved[restore_index] = restore_word;
      end
      if (reg_rd) begin
         nxt_st.rdata = '0;
         if (reg_addr >= A_SAVED_FIRST && reg_addr <= A_SAVED_LAST) begin
            nxt_st.rdata = {{PARAM_PAD_HI{1'b0}}, st_ff.saved[reg_addr[2:0]]};
         end else if (reg_addr >= A_AUX_FIRST && reg_addr <= A_AUX_LAST) begin
            nxt_st.rdata = {20'h00000, st_ff.aux[2'(reg_addr - A_AUX_FIRST)]};
         end else begin
            case (reg_addr)
               A_PIN_LEVEL:  nxt_st.rdata = {20'h00000, st_ff.pin_lvl};
               A_CORE_CTRL:  nxt_st.rdata = {16'h0000, st_ff.core};
               A_SER_OUT:    nxt_st.rdata = {16'h0000, st_ff.ser_out};
               A_SER_IN:     nxt_st.rdata = {24'h000000, st_ff.ser_in};
               A_PIN_CFG_LO: nxt_st.rdata = {8'h00, st_ff.pin_cfg[0]};
               A_PIN_CFG_HI: nxt_st.rdata = {8'h00, st_ff.pin_cfg[1]};
               A_AUX_PWR:    nxt_st.rdata = {16'h0000, st_ff.aux_pwr};
               A_AUX_EN:     nxt_st.rdata = {16'h0000, st_ff.aux_on, 15'h0000};
               A_OSC_OFF:    nxt_st.rdata = {29'h00000000, st_ff.osc_off, 2'b00};
               A_DAC_CFG:    nxt_st.rdata = {16'h0000, st_ff.dac};
               default:      nxt_st.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata               = st_ff.rdata;
   assign save_start              = st_ff.save_start;
   assign save_words              = st_ff.snap;
   assign multipurpose_pin_levels = st_ff.pin_out;
   assign core_control            = st_ff.core;
   assign serial_out_control      = st_ff.ser_out;
   assign serial_in_control       = st_ff.ser_in;
   assign pin_config              = st_ff.pin_cfg;
   assign aux_filter_select       = st_ff.aux_pwr[B_FILTER_LO +: 2];
   assign aux_and_power_control   = st_ff.aux_pwr;
   assign aux_converter_on        = st_ff.aux_on;
   assign oscillator_off          = st_ff.osc_off;
   assign dac_config              = st_ff.dac;

   // dsp sees 4 zero msbs, the 1.11 result, then 12 zero lsbs
   for (genvar g = 0; g < NUM_AUX; g++) begin : g_aux
      assign aux_param_word[g] = {{PARAM_PAD_HI{1'b0}}, st_ff.aux[g],
                                  {AUX_PAD_LO{1'b0}}};
   end

   a_saved_top_zero: assert property (@(posedge clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == A_SAVED_FIRST) |=> reg_rdata[31:28] == 4'h0)
      else $error("saved parameter read shows nonzero top bits");

   a_saved_refresh: assert property (@(posedge clk) disable iff (reset)
      (clk_en && frame_tick && !core_control[B_SAVED_PORT_WR] && !restore_valid && !reg_wr)
      |=> st_ff.saved == $past(param_ram_word))
      else $error("saved words not refreshed on frame tick");

   a_save_pulse: assert property (@(posedge clk) disable iff (reset)
      (clk_en && save_edge) |=> (save_start && save_words == $past(st_ff.saved)))
      else $error("trigger edge did not start a save");

   a_port_write_saved: assert property (@(posedge clk) disable iff (reset)
      (hwr && reg_addr == A_SAVED_FIRST && core_control[B_SAVED_PORT_WR] && !restore_valid)
      |=> st_ff.saved[0] == $past(reg_wdata[27:0]))
      else $error("host write to saved word lost in port-write mode");

   a_pin_write_lock: assert property (@(posedge clk) disable iff (reset)
      (hwr && reg_addr == A_PIN_LEVEL && !core_control[B_PIN_PORT_WR] && !frame_tick)
      |=> $stable(st_ff.pin_lvl))
      else $error("pin level changed by host outside port-write mode");

   a_pin_once_frame: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !frame_tick) |=> $stable(multipurpose_pin_levels))
      else $error("pin outputs changed between frame ticks");

   a_aux_full_scale: assert property (@(posedge clk) disable iff (reset)
      (clk_en && frame_tick && !core_control[B_AUX_PORT_WR] && aux_filter_select == 2'b00
       && aux_raw_code[0] == AUX_FULL_CODE && !reg_wr)
      |=> aux_param_word[0] == 28'h0800000)
      else $error("full-scale aux code did not map to 1.0");

   a_aux_read_zero: assert property (@(posedge clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == A_AUX_FIRST) |=> reg_rdata[31:12] == 20'h00000)
      else $error("aux result read shows bits above 11");

   a_core_write: assert property (@(posedge clk) disable iff (reset)
      (hwr && reg_addr == A_CORE_CTRL) |=> core_control == ($past(reg_wdata[15:0]) & 16'h31ff))
      else $error("core control write not stored with its mask");
endmodule // dsp_host_control_registers
`default_nettype wire

// [testbench/ctl_host_model.sv]
// host controller model: issues one register access at a time on the control port
`timescale 1ns/1ps
`default_nettype none
module ctl_host_model (
   input  wire logic                            clk,
   output logic      [ctl_regs_pkg::ADDR_W-1:0] reg_addr,
   output logic                                 reg_wr,
   output logic      [ctl_regs_pkg::DATA_W-1:0] reg_wdata,
   output logic                                 reg_rd,
   input  wire logic [ctl_regs_pkg::DATA_W-1:0] reg_rdata
);
   import ctl_regs_pkg::*;
   initial begin
      reg_addr  = '0;
      reg_wr    = 1'b0;
      reg_wdata = '0;
      reg_rd    = 1'b0;
   end
   // released data shows the inverse so a late capture cannot pass by luck
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk);
      #1;
      reg_rd   = 1'b0;
      d        = reg_rdata;
   endtask
endmodule // ctl_host_model
`default_nettype wire

// [testbench/dsp_host_control_registers_test.sv]
// self-checking bench for the host control register bank
`timescale 1ns/1ps
`default_nettype none
module dsp_host_control_registers_test;
   import ctl_regs_pkg::*;
   localparam logic [11:0] MA [13] = '{12'h81c, 12'h81e, 12'h81f, 12'h820, 12'h821, 12'h822,
      12'h824, 12'h826, 12'h827, 12'h81d, 12'h823, 12'h825, 12'h8ff};
   localparam logic [31:0] MM [13] = '{32'h31ff, 32'h3fff, 32'h1f, 32'hffffff, 32'hffffff,
      32'h3ef, 32'h8000, 32'h4, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
   logic                                 clk, clk_en, reset, reg_wr, reg_rd, frame_clk;
   logic                                 save_trigger, save_on_rising, save_start, restore_valid;
   logic [ADDR_W-1:0]                    reg_addr;
   logic [DATA_W-1:0]                    reg_wdata, reg_rdata;
   logic [NUM_SAVED-1:0][PARAM_W-1:0]    param_ram_word, save_words;
   logic [2:0]                           restore_index;
   logic [PARAM_W-1:0]                   restore_word;
   logic [NUM_PINS-1:0]                  multipurpose_pin_in, multipurpose_pin_levels;
   logic [NUM_AUX-1:0][AUX_RAW_W-1:0]    aux_raw_code;
   logic [NUM_AUX-1:0][AUX_W-1:0]        aux_filtered_code;
   logic [NUM_AUX-1:0][PARAM_W-1:0]      aux_param_word;
   logic [15:0]                          core_control, serial_out_control, aux_and_power_control;
   logic [15:0]                          dac_config;
   logic [7:0]                           serial_in_control;
   logic [47:0]                          pin_config;
   logic [1:0]                           aux_filter_select;
   logic                                 aux_converter_on, oscillator_off;
   int                                   err_total, n_checks;
   dsp_host_control_registers dut (.clk(clk), .clk_en(clk_en), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .frame_clk(frame_clk), .param_ram_word(param_ram_word), .save_trigger(save_trigger),
      .save_on_rising(save_on_rising), .save_start(save_start), .save_words(save_words),
      .restore_valid(restore_valid), .restore_index(restore_index), .restore_word(restore_word),
      .multipurpose_pin_in(multipurpose_pin_in), .multipurpose_pin_levels(multipurpose_pin_levels),
      .aux_raw_code(aux_raw_code), .aux_filtered_code(aux_filtered_code),
      .aux_param_word(aux_param_word), .core_control(core_control),
      .serial_out_control(serial_out_control), .serial_in_control(serial_in_control),
      .pin_config(pin_config), .aux_filter_select(aux_filter_select),
      .aux_and_power_control(aux_and_power_control), .aux_converter_on(aux_converter_on),
      .oscillator_off(oscillator_off), .dac_config(dac_config));
   ctl_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic summarize();
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      host.rd(a, d);
      chk(nm, e, d);
   endtask
   // the frame pin is synchronised, so it stays high long enough for two flops to see it
   task automatic frame();
      @(posedge clk);
      #1 frame_clk = 1'b1;
      repeat (4) @(posedge clk);
      #1 frame_clk = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_save(input string nm, input logic want);
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(posedge clk);
         #1 if (save_start === 1'b1) seen = 1'b1;
      end
      chk(nm, want, seen);
   endtask
   task automatic t_reset_and_masks();
      foreach (MA[i]) rchk("reset value", MA[i], 32'h0);
      rchk("reset saved", 12'h800, 32'h0);
      rchk("reset aux", 12'h809, 32'h0);
      foreach (MA[i]) host.wr(MA[i], 32'hffffffff);
      foreach (MA[i]) rchk("writable bits", MA[i], MM[i]);
      chk("filter select", 2'h3, aux_filter_select);
      chk("aux on", 1'b1, aux_converter_on);
      chk("osc off", 1'b1, oscillator_off);
      chk("core out", 16'h31ff, core_control);
      chk("ser out", 16'h3fff, serial_out_control);
      chk("ser in", 8'h1f, serial_in_control);
      chk("aux pwr", 16'h03ef, aux_and_power_control);
      chk("dac cfg", 16'h0003, dac_config);
      foreach (MA[i]) host.wr(MA[i], 32'h0);
      host.wr(12'h820, 32'h00123456);
      host.wr(12'h821, 32'h00abcdef);
      chk("pin config", 48'habcdef123456, pin_config);
   endtask
   task automatic t_saved();
      host.wr(12'h807, 32'hffffffff);
      rchk("saved refused", 12'h807, 32'h0);
      host.wr(12'h81c, 32'h40);
      host.wr(12'h807, 32'hffffffff);
      rchk("saved host", 12'h807, 32'h0fffffff);
      for (int i = 0; i < NUM_SAVED; i++) param_ram_word[i] = 28'hfedcba0 | 28'(i);
      frame();
      rchk("saved kept", 12'h807, 32'h0fffffff);
      host.wr(12'h81c, 32'h0);
      frame();
      for (int i = 0; i < NUM_SAVED; i++)
         rchk("saved refresh", 12'h800 + 12'(i), {4'h0, param_ram_word[i]});
   endtask
   task automatic t_pins();
      multipurpose_pin_in = 12'ha5c;
      frame();
      rchk("pin sample", 12'h808, 32'h0a5c);
      multipurpose_pin_in = 12'h3c1;
      repeat (8) @(posedge clk);
      rchk("pin between frames", 12'h808, 32'h0a5c);
      frame();
      chk("pin out", 12'ha5c, multipurpose_pin_levels);
      host.wr(12'h808, 32'hffff);
      rchk("pin refused", 12'h808, 32'h03c1);
      host.wr(12'h81c, 32'h80);
      host.wr(12'h808, 32'hf123);
      rchk("pin host", 12'h808, 32'h0123);
      frame();
      rchk("pin held", 12'h808, 32'h0123);
      chk("pin driven", 12'h123, multipurpose_pin_levels);
      host.wr(12'h81c, 32'h0);
   endtask
   task automatic t_aux();
      logic [11:0] ex [4];
      aux_raw_code = '{8'h00, 8'h01, 8'h80, 8'hff};
      ex = '{12'h800, 12'h400, 12'h008, 12'h000};
      frame();
      for (int i = 0; i < NUM_AUX; i++) begin
         rchk("aux raw", 12'h809 + 12'(i), {20'h0, ex[i]});
         chk("aux word", {4'h0, ex[i], 12'h0}, aux_param_word[i]);
      end
      aux_filtered_code = '{12'h800, 12'h123, 12'h7ff, 12'hfff};
      for (int f = 1; f < 4; f++) begin
         host.wr(12'h822, 32'(f) << 8);
         frame();
         rchk("aux filtered", 12'h80a, 32'h7ff);
      end
      rchk("aux clamp", 12'h809, 32'h800);
      host.wr(12'h80a, 32'hffff);
      rchk("aux refused", 12'h80a, 32'h7ff);
      host.wr(12'h81c, 32'h100);
      host.wr(12'h80a, 32'hffff);
      frame();
      rchk("aux host", 12'h80a, 32'h0fff);
      host.wr(12'h81c, 32'h0);
      host.wr(12'h822, 32'h0);
   endtask
   // a write offered while the clock enable is low must leave no trace
   task automatic t_freeze();
      @(posedge clk);
      #1 clk_en = 1'b0;
      host.wr(12'h81e, 32'h1234);
      clk_en = 1'b1;
      rchk("frozen write", 12'h81e, 32'h0);
      chk("frozen out", 16'h0000, serial_out_control);
   endtask
   task automatic t_save_restore();
      save_on_rising = 1'b1;
      save_trigger = 1'b1;
      wait_save("save rising", 1'b1);
      chk("save word", param_ram_word[5], save_words[5]);
      save_on_rising = 1'b0;
      @(posedge clk);
      #1 restore_valid = 1'b1;
      restore_index = 3'h3;
      restore_word = 28'h1234567;
      @(posedge clk);
      #1 restore_valid = 1'b0;
      rchk("restored", 12'h803, 32'h01234567);
      save_trigger = 1'b0;
      wait_save("save falling", 1'b1);
      chk("save restored", 28'h1234567, save_words[3]);
      save_trigger = 1'b1;
      wait_save("no save on rise", 1'b0);
   endtask
   initial begin
      err_total = 0;
      n_checks = 0;
      clk_en = 1'b1;
      reset = 1'b1;
      {frame_clk, save_trigger, save_on_rising, restore_valid} = 4'h0;
      restore_index = 3'h0;
      restore_word = '0;
      param_ram_word = '0;
      multipurpose_pin_in = '0;
      aux_raw_code = '0;
      aux_filtered_code = '0;
      repeat (4) @(posedge clk);
      #1 reset = 1'b0;
      t_reset_and_masks();
      t_saved();
      t_pins();
      t_aux();
      t_save_restore();
      t_freeze();
      summarize();
   end
   // the sequence needs well under a thousand cycles
   initial begin
      #400000;
      err_total++;
      summarize();
   end
endmodule // dsp_host_control_registers_test
`default_nettype wire
